// ==== tb.sv ====
`timescale 1ns/1ps
// Bench: bus master, read scoreboard, expiry timing
module tb;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0000_0000;
  reg [3:0] avs_byteenable = 4'h0;
  reg xtal_in = 1'b0;
  reg supply_monitor_irq = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire wdt_reset_req;
  wire watchdog_int;
  wire irq;
  integer n_fail = 0;
  integer checked = 0;
  integer rsts = 0; // Reset pulses seen
  integer r0;
  integer p;
  reg [31:0] lf = 32'he57c; // Stimulus LFSR state
  reg [31:0] q[$]; // Expected read data, oldest first
  // Short base exponent keeps periods to a few crystal ticks
  wdt_ctrl #(.BASE_SHIFT(2)) wdt_ctrl_inst (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .xtal_in(xtal_in),
    .supply_monitor_irq(supply_monitor_irq), .wdt_reset_req(wdt_reset_req),
    .watchdog_int(watchdog_int), .irq(irq));
  initial forever #50 core_clk = ~core_clk;
  // Crystal free-runs, phase unrelated to the core clock
  initial forever #15259 xtal_in = ~xtal_in;
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task conclude;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Scoreboard: a finished read takes the oldest note
  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      chk("readdata", q.pop_front(), avs_readdata);
    if (wdt_reset_req === 1'b1)
      rsts = rsts + 1;
  end
  // One Avalon access; held until waitrequest is seen low
  task bus(input rd, input [3:0] a, input [7:0] d);
    integer n;
    begin
      lf = nx(lf);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= {lf[31:8], d}; // Upper bits are don't-care
      avs_byteenable <= {lf[3:1], 1'b1};
      if (rd)
        q.push_back({24'h00_0000, d});
      n = 0;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
        @(posedge core_clk);
        n = n + 1;
        if (n > 20) begin
          n_fail = n_fail + 1;
          conclude;
        end
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // Unlock, then the real control write
  task ctl(input [7:0] d);
    begin
      bus(1'b0, 4'h0, 8'h01);
      bus(1'b0, 4'h0, d);
    end
  endtask
  // Expiry must land inside its crystal-tick window
  task tmo(input [3:0] c, input s);
    integer n;
    integer hi;
    begin
      hi = (c > 7) ? 20 : (305 << (c + 2)) + 50;
      n = 0;
      while ((s ? watchdog_int : wdt_reset_req) !== 1'b1) begin
        @(posedge core_clk);
        n = n + 1;
        if (n > hi) begin
          n_fail = n_fail + 1;
          conclude;
        end
      end
      chk("expiry", 1, (c > 7) || (n > hi - 405));
    end
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'h4, 8'h00);
    bus(1'b1, 4'hc, 8'h00);
    bus(1'b0, 4'h0, 8'h72);
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b0, 4'h0, 8'h01);
    bus(1'b1, 4'h4, 8'h00);
    bus(1'b0, 4'h0, 8'h02);
    bus(1'b1, 4'h0, 8'h00);
    $display("end of test access");
    ctl(8'h02);
    tmo(4'h0, 1'b0);
    chk("irq", 0, irq);
    bus(1'b1, 4'h0, 8'h04);
    bus(1'b1, 4'h4, 8'h03);
    bus(1'b0, 4'h4, 8'h03);
    bus(1'b1, 4'h4, 8'h00);
    $display("end of test reset response");
    bus(1'b0, 4'h8, 8'h01);
    bus(1'b1, 4'h8, 8'h01);
    r0 = rsts;
    // Codes 4..7 left out: too many ticks for this run
    for (p = 0; p < 4; p = p + 1) begin
      ctl({p[3:0], 4'ha});
      tmo(p[3:0], 1'b1);
      chk("irq", 1, irq);
      bus(1'b0, 4'h8, 8'h00);
      chk("watchdog_int", 1, watchdog_int);
      bus(1'b1, 4'h0, {p[3:0], 4'he});
      ctl(8'h00);
      chk("watchdog_int", 0, watchdog_int);
      bus(1'b0, 4'h4, 8'h01);
      bus(1'b0, 4'h8, 8'h01);
    end
    chk("resets", r0, rsts);
    bus(1'b0, 4'h4, 8'h01);
    chk("irq", 0, irq);
    $display("end of test interrupt response");
    r0 = rsts;
    ctl(8'h12);
    repeat (4) begin
      repeat (1800) @(posedge core_clk);
      ctl(8'h12);
    end
    chk("resets", r0, rsts);
    tmo(4'h1, 1'b0);
    ctl(8'h82);
    tmo(4'h8, 1'b0);
    bus(1'b1, 4'h0, 8'h84);
    ctl(8'h92);
    tmo(4'h9, 1'b0);
    bus(1'b1, 4'h0, 8'h94);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b1, 4'h0, 8'h00);
    $display("end of test kick and immediate");
    ctl(8'h12);
    supply_monitor_irq <= 1'b1;
    @(posedge core_clk);
    supply_monitor_irq <= 1'b0;
    bus(1'b1, 4'h0, 8'h10);
    bus(1'b1, 4'h4, 8'h04);
    r0 = rsts;
    repeat (3000) @(posedge core_clk);
    chk("resets", r0, rsts);
    $display("end of test supply");
    conclude;
  end
endmodule
bind wdt_ctrl wdt_ctrl_chk #(.BASE_SHIFT(BASE_SHIFT)) wdt_ctrl_chk_inst (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .wdt_reset_req(wdt_reset_req),
  .watchdog_int(watchdog_int));

// ==== wdt_ctrl.v ====
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "wdt_defs.vh"

// Contract
// R1: Codes 3..7 give 125 to 2000 ms; 8 resets
// R2: Select bit set: timeout interrupts instead of resetting
// R3: Watchdog interrupt ignores the global interrupt enable
// R4: Watchdog interrupt has fixed, unchangeable high priority
// R5: Any timeout sets the timeout flag
// R6: Flag cleared by writing zero or hardware reset
// R7: Watchdog reset leaves the timeout flag set
// R8: Writing arm one enables and restarts counting
// R9: Software rearms each period, else reset or interrupt
// R10: Arm cleared by zero, watchdog reset, reset, supply
// R11: Unlock write, then very next write updates register
// R12: Software masks interrupts around the unlock sequence
// R13: Period is 2^pre times 512 crystal periods
// R14: Unlocked only for the one following access
module wdt_ctrl #(
  parameter BASE_SHIFT = `WDT_BASE_SHIFT
) (
  input wire core_clk,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire xtal_in,
  input wire supply_monitor_irq,
  output reg wdt_reset_req,
  output reg watchdog_int,
  output wire irq
);

  // Bus handshake state
  wire req; // Any request present
  reg ack_q; // Second cycle of a request
  wire done; // Edge at which the access completes
  wire sel_ctrl; // Address hits watchdog_control
  wire sel_stat; // Address hits the event status word
  wire sel_mask; // Address hits the event mask word
  wire wr_ctrl; // Completing write to watchdog_control
  wire wr_stat; // Completing write to status
  wire wr_mask; // Completing write to mask

  // Control register fields
  reg [3:0] pre_q; // Prescale code
  reg respond_with_interrupt_q; // Interrupt instead of reset
  reg timeout_flag_q; // Timeout has happened
  reg watchdog_arm_q; // Watchdog running
  reg write_unlock_q; // Next access may write the register

  // Timebase and counter
  wire xtal_level; // Filtered crystal level
  wire xtal_tick; // One pulse per crystal period
  wire expire; // Period elapsed while armed
  wire apply; // Unlocked control write takes effect
  wire kick; // Software writes arm as one

  // Timeout decisions
  wire immediate; // Code 8 or above while armed
  wire reset_evt; // Timeout answered by reset
  wire int_evt; // Timeout answered by interrupt
  wire timeout_evt; // Any timeout
  wire supply_evt; // Supply monitor disarmed the watchdog

  // Event status and mask
  reg [`WDT_EVT_W-1:0] evt_q; // Sticky event bits
  reg [`WDT_EVT_W-1:0] mask_q; // Event enables
  wire [`WDT_EVT_W-1:0] evt_set; // Events this cycle
  wire [`WDT_EVT_W-1:0] evt_clr; // Write-one-to-clear pattern
  reg [31:0] rd_mux; // Read data before it is registered

  // Address decode
  assign sel_ctrl = (avs_address == `WDT_OFS_CTRL);
  assign sel_stat = (avs_address == `WDT_OFS_STAT);
  assign sel_mask = (avs_address == `WDT_OFS_MASK);

  // One wait cycle per access: data is registered before it is shown
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign done = req & ack_q;

  // Writes only count through byte lane zero, where all fields sit
  assign wr_ctrl = done & avs_write & sel_ctrl & avs_byteenable[0];
  assign wr_stat = done & avs_write & sel_stat & avs_byteenable[0];
  assign wr_mask = done & avs_write & sel_mask & avs_byteenable[0];

  // Handshake phase tracking
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      // Drops at completion so back to back requests wait again
      ack_q <= req & ~ack_q;
    end
  end

  // Read mux; unmapped words read as zero
  always @* begin
    rd_mux = `WDT_RD_RST;
    if (sel_ctrl) begin
      rd_mux[`WDT_PRE_HI:`WDT_PRE_LO] = pre_q;
      rd_mux[`WDT_IRQSEL_BIT] = respond_with_interrupt_q;
      rd_mux[`WDT_FLAG_BIT] = timeout_flag_q;
      rd_mux[`WDT_ARM_BIT] = watchdog_arm_q;
      rd_mux[`WDT_UNLOCK_BIT] = write_unlock_q;
    end else if (sel_stat) begin
      rd_mux[`WDT_EVT_W-1:0] = evt_q;
    end else if (sel_mask) begin
      rd_mux[`WDT_EVT_W-1:0] = mask_q;
    end
  end

  // Capture read data in the wait cycle; it stands at the completing edge
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= `WDT_RD_RST;
    end else if (avs_read & ~ack_q) begin
      avs_readdata <= rd_mux;
    end
  end

  // Unlock window
  // Any completed access closes an open window, so a stray access between
  // the unlock and the real write costs the software a fresh unlock.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_unlock_q <= 1'b0;
    end else if (done) begin
      if (write_unlock_q) begin
        // Window used or wasted by this access
        write_unlock_q <= 1'b0; // see R14
      end else begin
        // Locked write with the unlock bit opens the window only
        write_unlock_q <= wr_ctrl & avs_writedata[`WDT_UNLOCK_BIT]; // see R11
      end
    end
  end

  // Only the access right after the unlock may change fields
  assign apply = wr_ctrl & write_unlock_q; // see R11
  assign kick = apply & avs_writedata[`WDT_ARM_BIT];

  // Prescale and response select
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_q <= `WDT_PRE_RST;
      respond_with_interrupt_q <= 1'b0;
    end else if (apply) begin
      pre_q <= avs_writedata[`WDT_PRE_HI:`WDT_PRE_LO];
      respond_with_interrupt_q <= avs_writedata[`WDT_IRQSEL_BIT]; // see R2
    end
  end

  // Crystal timebase, brought in from the pin
  wdt_sync u_xtal_sync (
    .clk(core_clk),
    .rst(rst),
    .din(xtal_in),
    .level_q(xtal_level),
    .rise_q(xtal_tick)
  );

  // Period counter; a kick restarts it from zero
  wdt_period_counter #(
    .BASE_SHIFT(BASE_SHIFT)
  ) u_period (
    .clk(core_clk),
    .rst(rst),
    .tick(xtal_tick & xtal_level),
    .clear(kick), // see R8
    .run(watchdog_arm_q),
    .pre(pre_q), // see R13
    .expire_q(expire)
  );

  // Reserved codes above 8 are treated as code 8: safest failure mode
  assign immediate = watchdog_arm_q & (pre_q >= `WDT_PRE_IMMEDIATE); // see R1

  // Immediate reset ignores the response select
  assign reset_evt = watchdog_arm_q & ((expire & ~respond_with_interrupt_q) | immediate); // see R9
  assign int_evt = watchdog_arm_q & expire & respond_with_interrupt_q & ~immediate; // see R2
  assign timeout_evt = reset_evt | int_evt;
  assign supply_evt = supply_monitor_irq & watchdog_arm_q;

  // Arm bit
  // Hardware clears win over a software kick: a failing supply or a reset
  // being issued must not leave a live watchdog behind.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      watchdog_arm_q <= 1'b0; // see R10
    end else if (supply_monitor_irq | reset_evt) begin
      // Supply event or own reset disarms
      watchdog_arm_q <= 1'b0; // see R10
    end else if (apply) begin
      // Write of one arms, zero disarms
      watchdog_arm_q <= avs_writedata[`WDT_ARM_BIT]; // see R8
    end
  end

  // Timeout flag
  // Only rst clears it by hardware; the watchdog reset goes out on
  // wdt_reset_req and must not be wired back to rst, or the cause is lost.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timeout_flag_q <= 1'b0; // see R6
    end else if (timeout_evt) begin
      // Set wins over a same-cycle clear
      timeout_flag_q <= 1'b1; // see R5
    end else if (apply & ~avs_writedata[`WDT_FLAG_BIT]) begin
      timeout_flag_q <= 1'b0; // see R6
    end
  end

  // Reset request pulse toward the system reset logic
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdt_reset_req <= 1'b0;
    end else begin
      // Block state survives; the flag and the status reset event bit tell the cause afterwards
      wdt_reset_req <= reset_evt; // see R7
    end
  end

  // Dedicated interrupt line
  // It runs straight to the core's top-priority input, outside the global
  // enable and the priority registers, so software cannot mute or demote it.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      watchdog_int <= 1'b0;
    end else if (int_evt) begin
      // Set wins over a same-cycle acknowledge
      watchdog_int <= 1'b1; // see R3
    end else if (apply & ~avs_writedata[`WDT_FLAG_BIT]) begin
      // Acknowledged by clearing the timeout flag
      watchdog_int <= 1'b0; // see R4
    end
  end

  // Event sources for the maskable bus interrupt
  assign evt_set[`WDT_EVT_TIMEOUT] = timeout_evt;
  assign evt_set[`WDT_EVT_RESET] = reset_evt;
  assign evt_set[`WDT_EVT_SUPPLY] = supply_evt;
  assign evt_clr = wr_stat ? avs_writedata[`WDT_EVT_W-1:0] : `WDT_EVT_RST;

  // Sticky status, write one to clear, new events win
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt_q <= `WDT_EVT_RST;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  // Mask register
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_q <= `WDT_EVT_RST;
    end else if (wr_mask) begin
      mask_q <= avs_writedata[`WDT_EVT_W-1:0];
    end
  end

  // Level interrupt while any enabled event is pending
  assign irq = |(evt_q & mask_q);

endmodule

// ==== wdt_ctrl_chk.sv ====
`timescale 1ns/1ps
// Port-level checks of the watchdog control block
module wdt_ctrl_chk #(
  parameter BASE_SHIFT = 9
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic wdt_reset_req,
  input wire logic watchdog_int
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // First cycle of a request always waits
  property p_wfirst;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wfirst: assert property (p_wfirst) else $error("no wait cycle");
  // At most one wait cycle per request
  property p_wack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wack: assert property (p_wack) else $error("late bus answer");
  // Reset request and watchdog interrupt quiet on leaving hardware reset
  property p_rst_clear;
    $fell(rst) |-> !wdt_reset_req && !watchdog_int;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left output high");
  // Reset request is a single pulse
  property p_pulse;
    wdt_reset_req |=> !wdt_reset_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  // Watchdog reset disarms: no pulse nine cycles later when the eight cycles between have no write
  property p_disarm;
    wdt_reset_req ##1 (!avs_write) [*8] |=> !wdt_reset_req;
  endproperty
  a_disarm: assert property (p_disarm) else $error("still armed after reset");
  // Interrupt response never comes with a reset
  property p_int_rst;
    $rose(watchdog_int) |-> !wdt_reset_req && !$past(wdt_reset_req);
  endproperty
  a_int_rst: assert property (p_int_rst) else $error("reset with interrupt");
  // Only a control write can drop the interrupt, never masking
  property p_int_hold;
    watchdog_int && !(avs_write && avs_address == 4'h0) |=> watchdog_int;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped");
  // Flag reads set while the interrupt stands
  property p_flag_int;
    avs_read && !avs_waitrequest && avs_address == 4'h0 && watchdog_int
      && $past(watchdog_int) |-> avs_readdata[2];
  endproperty
  a_flag_int: assert property (p_flag_int) else $error("flag clear on timeout");
endmodule

// ==== wdt_defs.vh ====
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// Byte offsets of the 32-bit register words
`define WDT_OFS_CTRL 4'h0
`define WDT_OFS_STAT 4'h4
`define WDT_OFS_MASK 4'h8

// Field positions inside watchdog_control
`define WDT_PRE_HI 7
`define WDT_PRE_LO 4
`define WDT_IRQSEL_BIT 3
`define WDT_FLAG_BIT 2
`define WDT_ARM_BIT 1
`define WDT_UNLOCK_BIT 0

// Reset values
`define WDT_PRE_RST 4'h0
`define WDT_EVT_RST 3'h0
`define WDT_RD_RST 32'h0000_0000

// Event bits of the status and mask words
`define WDT_EVT_TIMEOUT 0
`define WDT_EVT_RESET 1
`define WDT_EVT_SUPPLY 2
`define WDT_EVT_W 3

// Timebase: crystal rate in Hz and base exponent (512 crystal periods)
`define WDT_XTAL_HZ 32768
`define WDT_BASE_SHIFT 9
// Prescale code that forces an immediate reset
`define WDT_PRE_IMMEDIATE 4'h8
// Width of the crystal period counter (up to 2^16 periods)
`define WDT_CNT_W 17

`endif

// ==== wdt_period_counter.v ====
`timescale 1ns/1ps
`include "wdt_defs.vh"
// Counts crystal ticks; pulses when 2^(pre+BASE_SHIFT) ticks have passed
module wdt_period_counter #(
  parameter BASE_SHIFT = `WDT_BASE_SHIFT
) (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire clear,
  input wire run,
  input wire [3:0] pre,
  output reg expire_q
);
  localparam [4:0] SHIFT = BASE_SHIFT[4:0]; // Base exponent, sized for the adder
  wire [`WDT_CNT_W-1:0] one; // Constant one at counter width
  wire [4:0] shamt; // Total exponent of the period
  wire [`WDT_CNT_W-1:0] limit; // Last count of the period
  reg [`WDT_CNT_W-1:0] cnt_q; // Ticks seen so far

  assign one = {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
  assign shamt = {2'b00, pre[2:0]} + SHIFT; // see R13
  assign limit = (one << shamt) - one;

  // Codes with pre[3] set never expire here; the top handles them at once
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {`WDT_CNT_W{1'b0}};
      expire_q <= 1'b0;
    end else if (clear | ~run) begin
      // Restart on a kick or while disarmed
      cnt_q <= {`WDT_CNT_W{1'b0}}; // see R8
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (tick & ~pre[3]) begin
        if (cnt_q == limit) begin
          // Period complete
          cnt_q <= {`WDT_CNT_W{1'b0}};
          expire_q <= 1'b1; // see R1
        end else begin
          cnt_q <= cnt_q + one;
        end
      end
    end
  end
endmodule

// ==== wdt_sync.v ====
`timescale 1ns/1ps
// Three-stage synchroniser with agreement filter and rising-edge pulse
module wdt_sync (
  input wire clk,
  input wire rst,
  input wire din,
  output reg level_q,
  output reg rise_q
);
  reg s1_q; // First stage, read only by s2_q
  reg s2_q; // Second stage
  reg s3_q; // Third stage

  // Level moves only once stages two and three agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      // One pulse per accepted low-to-high change
      rise_q <= (s2_q == s3_q) & s3_q & ~level_q;
    end
  end
endmodule
